/* File: core/stereo_duty_map.svh */
// Purpose: field widths, reset values and counts for the stereo gate and row duty block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef STEREO_DUTY_MAP_SVH
`define STEREO_DUTY_MAP_SVH

`define ROW_BLANK_DELAY_W   10
`define ROW_BLANK_DELAY_RST 10'h000
`define SCAN_TYPE_W         2
`define SCAN_TYPE_RST       2'h0
`define SCAN_PROGRESSIVE    2'h0
`define ENABLE_POL_RST      1'b0
`define STEREO_SEL_RST      1'b0
`define ARRAY_ROWS          1024
`define ROW_INDEX_W         10
`define LINE_COUNT_W        13
`define INIT_LINES          13'h0002

`endif

/* File: core/stereo_duty_pkg.sv */
// Purpose: shared types for the stereo gate and row duty block
// Assumes: nothing
// Notes:   constants live in stereo_duty_map.svh
package stereo_duty_pkg;

	typedef enum logic [1:0] {
		FRAME_HOLD    = 2'b00,
		FRAME_ACQUIRE = 2'b01
	} frame_state_e;

endpackage : stereo_duty_pkg

/* File: core/pin_sync_edge.sv */
// Purpose: two-stage synchroniser with edge detection for one pin
// Assumes: pin is asynchronous to clk
// Notes:   edges are found on the synchronised level only
`timescale 1ns/1ps
module pin_sync_edge (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// pin and results
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign level = stage2;
	assign rise  = stage2 & ~stage3;
	assign fall  = ~stage2 & stage3;
endmodule : pin_sync_edge

/* File: core/stereo_enable_and_row_duty_control.sv */
// Purpose: frame gate for stereo video input and row duty (row blanking) sequencing
// Assumes: hsync, vsync and frame gate are pins from the video source
// Notes:   configuration is loaded from plain ports on cfgWrite
//
// Overview of operation
// - inactive gate (stereo only): syncs still counted, acquire nothing
// - masked frame keeps previous image shown
// - polarity bit picks gate active level
// - stereo bit selects stereo or normal
// - gate sampled at vsync fall, next frame
// - line interleaved: gate applied per line
// - ten-bit delay, zero disables blanking
// - row shown 2W lines, then black
// - row N written Nth line after init
// - blank pulse exactly 2W lines after write
// - all rows share one delay
// - scan type resets to progressive
`timescale 1ns/1ps
`include "stereo_duty_map.svh"
module stereo_enable_and_row_duty_control
	import stereo_duty_pkg::*;
(
	// clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst,
	// video pins
	input  wire logic                            hsync,
	input  wire logic                            vsync,
	input  wire logic                            frameGate,
	// configuration load
	input  wire logic                            cfgWrite,
	input  wire logic                            cfgEnablePolaritySel,
	input  wire logic                            cfgStereoSelect,
	input  wire logic [`SCAN_TYPE_W-1:0]         cfgScanTypeSelect,
	input  wire logic [`ROW_BLANK_DELAY_W-1:0]   cfgRowBlankDelay,
	// configuration readback
	output logic                                 enablePolaritySel,
	output logic                                 stereoSelect,
	output logic [`SCAN_TYPE_W-1:0]              scanTypeSelect,
	output logic [`ROW_BLANK_DELAY_W-1:0]        rowOnTimeLimit,
	output logic                                 interlaced,
	// row sequencing
	output logic                                 frameAcquire,
	output logic                                 rowWrite,
	output logic [`ROW_INDEX_W-1:0]              rowWriteIndex,
	output logic                                 rowBlankPulse,
	output logic [`ROW_INDEX_W-1:0]              rowBlankIndex
);
	localparam logic [`LINE_COUNT_W-1:0] ROWS = `LINE_COUNT_W'(`ARRAY_ROWS);

	logic gateLevel;
	logic hsyncFall;
	logic vsyncFall;

	// every pin passes two flops before any logic reads it; an edge is seen in the same
	// cycle as the new level, so a pin pulse shorter than one clock can be lost
	pin_sync_edge gateSync (
		.clk   (clk),
		.rst   (rst),
		.pin   (frameGate),
		.level (gateLevel),
		.rise  (),
		.fall  ()
	);
	pin_sync_edge hsyncSync (
		.clk   (clk),
		.rst   (rst),
		.pin   (hsync),
		.level (),
		.rise  (),
		.fall  (hsyncFall)
	);
	pin_sync_edge vsyncSync (
		.clk   (clk),
		.rst   (rst),
		.pin   (vsync),
		.level (),
		.rise  (),
		.fall  (vsyncFall)
	);

	frame_state_e                     frameState;
	frame_state_e                     next_frameState;
	logic [`ROW_BLANK_DELAY_W-1:0]    activeDelay;
	logic [`LINE_COUNT_W-1:0]         lineCount;
	logic [`ARRAY_ROWS-1:0]           rowShown;

	// gate decision
	wire gateActive   = (gateLevel == enablePolaritySel);
	wire gateOpen     = ~stereoSelect | gateActive;
	assign next_frameState = gateOpen ? FRAME_ACQUIRE : FRAME_HOLD;

	// row write position
	wire [`LINE_COUNT_W-1:0] writeRow  = lineCount - `INIT_LINES;
	wire inRowArea  = (lineCount >= `INIT_LINES) && (writeRow < ROWS);
	wire acquiring  = (frameState == FRAME_ACQUIRE);
	wire doWrite    = hsyncFall & acquiring & gateOpen & inRowArea;

	// row blank position, same delay for every row
	wire [`LINE_COUNT_W-1:0] twiceW    =
		{{(`LINE_COUNT_W - `ROW_BLANK_DELAY_W - 1){1'b0}}, activeDelay, 1'b0};
	wire [`LINE_COUNT_W-1:0] blankRow  = lineCount - `INIT_LINES - twiceW;
	wire blankReach = (activeDelay != `ROW_BLANK_DELAY_RST) &&
		(lineCount >= `INIT_LINES + twiceW) && (blankRow < ROWS);
	wire [`ROW_INDEX_W-1:0] blankIdx   = blankRow[`ROW_INDEX_W-1:0];
	wire [`ROW_INDEX_W-1:0] writeIdx   = writeRow[`ROW_INDEX_W-1:0];
	wire doBlank    = hsyncFall & acquiring & blankReach & rowShown[blankIdx];

	// configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enablePolaritySel <= `ENABLE_POL_RST;
			stereoSelect      <= `STEREO_SEL_RST;
			scanTypeSelect    <= `SCAN_TYPE_RST;
			rowOnTimeLimit    <= `ROW_BLANK_DELAY_RST;
		end else if (cfgWrite) begin
			enablePolaritySel <= cfgEnablePolaritySel;
			stereoSelect      <= cfgStereoSelect;
			scanTypeSelect    <= cfgScanTypeSelect;
			rowOnTimeLimit    <= cfgRowBlankDelay;
		end
	end

	// interlace flag follows the scan type register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			interlaced <= 1'b0;
		end else begin
			interlaced <= (scanTypeSelect != `SCAN_PROGRESSIVE);
		end
	end

	// gate sample taken once per frame, at the vsync fall
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frameState <= FRAME_HOLD;
		end else if (vsyncFall) begin
			frameState <= next_frameState;
		end
	end

	// delay snapshot, so a delay written mid-frame waits for the next frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			activeDelay <= `ROW_BLANK_DELAY_RST;
		end else if (vsyncFall) begin
			activeDelay <= rowOnTimeLimit;
		end
	end

	// line count restarts at the vsync fall, which wins over an hsync fall
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lineCount <= '0;
		end else if (vsyncFall) begin
			lineCount <= '0;
		end else if (hsyncFall) begin
			lineCount <= lineCount + `LINE_COUNT_W'(1);
		end
	end

	// rows written in this frame; cleared at frame start so that a blank whose
	// position ran past the end of the last frame is never played late
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rowShown <= '0;
		end else if (vsyncFall) begin
			rowShown <= '0;
		end else begin
			if (doBlank) begin
				rowShown[blankIdx] <= 1'b0;
			end
			// a write wins over a blank of the same row
			if (doWrite) begin
				rowShown[writeIdx] <= 1'b1;
			end
		end
	end

	// acquire flag follows the frame state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frameAcquire <= 1'b0;
		end else begin
			frameAcquire <= acquiring;
		end
	end

	// row write strobe; the index holds the last written row
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rowWrite      <= 1'b0;
			rowWriteIndex <= '0;
		end else begin
			rowWrite      <= doWrite;
			rowWriteIndex <= doWrite ? writeIdx : rowWriteIndex;
		end
	end

	// row blank strobe; the index holds the last blanked row
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rowBlankPulse <= 1'b0;
			rowBlankIndex <= '0;
		end else begin
			rowBlankPulse <= doBlank;
			rowBlankIndex <= doBlank ? blankIdx : rowBlankIndex;
		end
	end
endmodule : stereo_enable_and_row_duty_control

/* File: verif/stereo_duty_sva.sv */
// Purpose: port assertions for the stereo gate and row duty block
// Assumes: bound to the top module, one clock domain
// Notes:   none
`timescale 1ns/1ps
`include "stereo_duty_map.svh"
module stereo_duty_sva (
	// watched ports
	input wire logic                          clk, rst, cfgWrite, cfgEnablePolaritySel,
	input wire logic                          cfgStereoSelect, enablePolaritySel, stereoSelect,
	input wire logic                          interlaced, frameAcquire, rowWrite, rowBlankPulse,
	input wire logic [`SCAN_TYPE_W-1:0]       cfgScanTypeSelect, scanTypeSelect,
	input wire logic [`ROW_BLANK_DELAY_W-1:0] cfgRowBlankDelay, rowOnTimeLimit,
	input wire logic [`ROW_INDEX_W-1:0]       rowWriteIndex
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_write_needs_acq:
		assert property (rowWrite |-> $past(frameAcquire)) else $error("write in held frame");
	a_blank_needs_acq:
		assert property (rowBlankPulse |-> $past(frameAcquire)) else $error("blank in held frame");
	a_cfg_pol_load:
		assert property (cfgWrite |=> enablePolaritySel == $past(cfgEnablePolaritySel)
			&& rowOnTimeLimit == $past(cfgRowBlankDelay)) else $error("polarity or delay load");
	a_cfg_mode_load:
		assert property (cfgWrite |=> stereoSelect == $past(cfgStereoSelect)
			&& scanTypeSelect == $past(cfgScanTypeSelect)) else $error("mode load");
	a_cfg_stands:
		assert property (!cfgWrite |=> $stable(rowOnTimeLimit) && $stable(stereoSelect))
			else $error("config changed without load");
	a_interlace_flag:
		assert property (1'b1 |=> interlaced == ($past(scanTypeSelect) != 2'h0))
			else $error("interlaced flag wrong");
	a_write_one_cycle:
		assert property (rowWrite |=> !rowWrite) else $error("row write too long");
	a_index_moves:
		assert property ($changed(rowWriteIndex) |-> rowWrite) else $error("index moved alone");
endmodule : stereo_duty_sva
bind stereo_enable_and_row_duty_control stereo_duty_sva chk (.clk, .rst, .cfgWrite,
	.cfgEnablePolaritySel, .cfgStereoSelect, .enablePolaritySel, .stereoSelect, .interlaced,
	.frameAcquire, .rowWrite, .rowBlankPulse, .cfgScanTypeSelect, .scanTypeSelect,
	.cfgRowBlankDelay, .rowOnTimeLimit, .rowWriteIndex);

/* File: verif/video_source.sv */
// Purpose: video source driving syncs and the stereo gate
// Assumes: syncs idle high
// Notes:   line period 125 ns
`timescale 1ns/1ps
module video_source (
	// video pins
	output logic hsync,
	output logic vsync,
	output logic frameGate
);
	initial begin
		hsync = 1'b1;
		vsync = 1'b1;
		frameGate = 1'b1;
	end
	// gate for a line settles half a line before its hsync fall
	task automatic frame(input int n, input logic g0, input logic tg);
		frameGate = g0;
		#100 vsync = 1'b0;
		#200 vsync = 1'b1;
		for (int l = 0; l < n; l++) begin
			frameGate = g0 ^ (tg & l[0]);
			#62.5 hsync = 1'b0;
			#62.5 hsync = 1'b1;
		end
		#300;
	endtask : frame
endmodule : video_source

/* File: verif/stereo_enable_and_row_duty_control_bench.sv */
// Purpose: self-checking bench for the stereo gate and row duty block
// Assumes: expected row pulses queued before each frame
// Notes:   none
`timescale 1ns/1ps
module stereo_enable_and_row_duty_control_bench;
	logic       clk = 1'b0, rst = 1'b1, cfgWrite = 1'b0, cfgEnablePolaritySel = 1'b0;
	logic       cfgStereoSelect = 1'b0, hsync, vsync, frameGate, enablePolaritySel;
	logic       stereoSelect, interlaced, frameAcquire, rowWrite, rowBlankPulse;
	logic [1:0] cfgScanTypeSelect = 2'h0, scanTypeSelect;
	logic [9:0] cfgRowBlankDelay = 10'h000, rowOnTimeLimit, rowWriteIndex, rowBlankIndex;
	logic [9:0] wq[$], bq[$];
	bit         written[1024];
	int         errors = 0, checked = 0;
	video_source src (.hsync, .vsync, .frameGate);
	stereo_enable_and_row_duty_control DUT (.clk, .rst, .hsync, .vsync, .frameGate, .cfgWrite,
		.cfgEnablePolaritySel, .cfgStereoSelect, .cfgScanTypeSelect, .cfgRowBlankDelay,
		.enablePolaritySel, .stereoSelect, .scanTypeSelect, .rowOnTimeLimit, .interlaced,
		.frameAcquire, .rowWrite, .rowWriteIndex, .rowBlankPulse, .rowBlankIndex);
	always #5 clk = ~clk;
	task automatic chk(input bit ok, input string m);
		checked++;
		if (!ok) begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	task automatic cfg(input logic p, input logic s, input logic [1:0] sc, input logic [9:0] w);
		@(posedge clk) #1;
		{cfgWrite, cfgEnablePolaritySel, cfgStereoSelect} = {1'b1, p, s};
		{cfgScanTypeSelect, cfgRowBlankDelay} = {sc, w};
		@(posedge clk) #1;
		cfgWrite = 1'b0;
		chk({enablePolaritySel, stereoSelect, scanTypeSelect, rowOnTimeLimit} === {p, s, sc, w},
			"readback");
		@(posedge clk) #1;
		chk(interlaced === (sc != 2'h0), "interlaced");
	endtask : cfg
	// queue the rows a frame must write and blank, then play it
	task automatic run(input int n, input logic g0, input logic tg);
		logic acq;
		int   w;
		w = int'(rowOnTimeLimit);
		acq = !stereoSelect || g0 === enablePolaritySel;
		written = '{default: 1'b0};
		for (int l = 2; l < n; l++) begin
			if (acq && (!stereoSelect || (g0 ^ (tg & l[0])) === enablePolaritySel)) begin
				wq.push_back(10'(l - 2));
				written[l - 2] = 1'b1;
			end
			if (acq && w != 0 && l >= 2 + 2 * w && written[l - 2 - 2 * w])
				bq.push_back(10'(l - 2 - 2 * w));
		end
		src.frame(n, g0, tg);
		chk(wq.size() == 0 && bq.size() == 0, "row pulse missing");
		chk(frameAcquire === acq, "frame acquire");
		$display("frame of %0d lines done", n);
	endtask : run
	always @(posedge clk) begin
		#2;
		if (rowWrite === 1'b1)
			chk(rowWriteIndex === wq.pop_front(), "row write");
		if (rowBlankPulse === 1'b1)
			chk(rowBlankIndex === bq.pop_front(), "row blank");
	end
	initial begin
		#200000;
		chk(1'b0, "timeout");
		end_of_test();
	end
	initial begin
		void'($urandom(32'h75d8));
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		chk({rowOnTimeLimit, scanTypeSelect, frameAcquire} === 13'h0000, "reset");
		cfg(1'b0, 1'b0, 2'h0, 10'h000);
		run(8, 1'b1, 1'b0);
		cfg(1'b1, 1'b0, 2'h0, 10'h003);
		run(14, 1'b1, 1'b0);
		repeat (2) begin
			cfg(1'b0, 1'b0, 2'h0, 10'($urandom_range(3, 1)));
			fork
				run($urandom_range(12, 8), 1'b1, 1'b0);
				begin
					#900;
					cfg(1'b0, 1'b0, 2'h0, 10'($urandom_range(6, 4)));
				end
			join
		end
		for (int p = 0; p < 4; p++) begin
			cfg(p[0], 1'b1, 2'h0, 10'h001);
			run(8, p[1], 1'b0);
		end
		cfg(1'b1, 1'b1, 2'h0, 10'h002);
		run(12, 1'b1, 1'b1);
		cfg(1'b0, 1'b0, 2'h2, 10'h000);
		end_of_test();
	end
endmodule : stereo_enable_and_row_duty_control_bench
